/* hw/sync_sram_port.sv */
// single-port synchronous static memory, device side of the pins
`timescale 1ns/100ps
`default_nettype none

module sync_sram_port #(
	parameter int ADDR_W = sync_sram_pkg::ADDR_W,
	parameter int DATA_W = sync_sram_pkg::DATA_W
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	// control pins from the host
	input  wire logic              chip_select_n,
	input  wire logic              write_enable_n,
	input  wire logic              output_enable_n,
	// address pins from the host
	input  wire logic [ADDR_W-1:0] word_address_in,
	// shared data bus, split into its three parts
	input  wire logic [DATA_W-1:0] data_io_bus_in,
	output logic      [DATA_W-1:0] data_io_bus_out,
	output logic                   data_io_bus_oe
);

	// the host is logic on this same clock, so its pins are sampled directly;
	// a board-level part would need setup/hold met instead of synchronisers
	localparam int DEPTH = 1 << ADDR_W;     // words in the array
	// the array is meant to land on a memory macro, so it takes no reset
	// and costs nothing at start-up; software must not trust unwritten words

	// storage: no reset, contents are undefined until first written
	logic [DATA_W-1:0] mem_r [DEPTH];

	// decoded operation at this rising edge
	logic              sel;                  // device selected
	logic              rd_op;                // read launched
	logic              wr_op;                // write launched

	// registered pin drivers
	logic [DATA_W-1:0] dout_r;               // last word read
	logic              oe_r;                 // data pins driven

	// decode: nothing starts while deselected; read and write exclude each
	// other on one edge, which keeps the array single-ported
	assign sel   = ~chip_select_n;
	assign rd_op = sel & write_enable_n;
	assign wr_op = sel & ~write_enable_n;

	// array write port; only the rising edge is used, so the falling
	// edge can never launch anything
	always_ff @(posedge clk) begin
		if (wr_op) begin
			// full 16-bit word stored at the 17-bit address
			mem_r[word_address_in] <= data_io_bus_in;
		end
	end

	// read data register; a read fetches the word even with outputs off,
	// so the internal access happens either way
	always_ff @(posedge clk) begin
		if (!resetn) begin
			dout_r <= DATA_W'(sync_sram_pkg::DOUT_RST);
		end else if (rd_op) begin
			// one op per edge, so a write before this read is already in place
			dout_r <= mem_r[word_address_in];
		end
	end

	// pin drive enable; registered so the output comes from a flop, which
	// costs one cycle from the sampling edge to the bus turning around
	always_ff @(posedge clk) begin
		if (!resetn) begin
			oe_r <= sync_sram_pkg::OE_RST;
		end else if (!sel) begin
			// deselected: released whatever the other pins show
			oe_r <= 1'b0;
		end else if (wr_op) begin
			// output enable has no say during a write
			oe_r <= 1'b0;
		end else begin
			// read: drive only when outputs are enabled
			oe_r <= ~output_enable_n;
		end
	end

	// outputs straight from flops; the three-state buffer itself sits in
	// the pad ring, fed by the out word and the drive enable
	assign data_io_bus_out = dout_r;
	assign data_io_bus_oe  = oe_r;

	// helper for read-after-write checking: last write seen
	logic [ADDR_W-1:0] h_wa_r;               // last written address
	logic [DATA_W-1:0] h_wd_r;               // last written word
	logic              h_wv_r;               // a write has been seen

	// helper capture, read only by the assertions and the write-then-read cover
	always_ff @(posedge clk) begin
		if (!resetn) begin
			h_wv_r <= 1'b0;
			h_wa_r <= '0;
			h_wd_r <= '0;
		end else if (wr_op) begin
			h_wv_r <= 1'b1;
			h_wa_r <= word_address_in;
			h_wd_r <= data_io_bus_in;
		end
	end

	// a write stores the whole bus word at the sampled address
	property p_write_stores;
		@(posedge clk) disable iff (!resetn)
		wr_op |=> mem_r[$past(word_address_in)] == $past(data_io_bus_in);
	endproperty
	a_write_stores: assert property (p_write_stores)
		else $error("write did not store the bus word");

	// a read returns the stored word on the next cycle
	property p_read_word;
		@(posedge clk) disable iff (!resetn)
		rd_op |=> data_io_bus_out == $past(mem_r[word_address_in]);
	endproperty
	a_read_word: assert property (p_read_word)
		else $error("read data differs from stored word");

	// deselected edge changes neither read data nor the addressed word;
	// words are undefined before any write, so the array half waits for one
	property p_desel_idle;
		@(posedge clk) disable iff (!resetn)
		chip_select_n |=> $stable(data_io_bus_out)
			&& (!$past(h_wv_r)
			|| mem_r[$past(word_address_in)] == $past(mem_r[word_address_in]));
	endproperty
	a_desel_idle: assert property (p_desel_idle)
		else $error("operation started while deselected");

	// every deselected edge leaves the bus released on the next cycle,
	// whatever write enable and output enable show
	property p_desel_hiz;
		@(posedge clk) disable iff (!resetn)
		chip_select_n |=> !data_io_bus_oe;
	endproperty
	a_desel_hiz: assert property (p_desel_hiz)
		else $error("bus driven while deselected");

	// read with outputs enabled drives the pins
	property p_read_drive;
		@(posedge clk) disable iff (!resetn)
		(rd_op && !output_enable_n) |=> data_io_bus_oe;
	endproperty
	a_read_drive: assert property (p_read_drive)
		else $error("enabled read left the bus released");

	// read with outputs disabled still fetches but keeps pins released
	property p_read_quiet;
		@(posedge clk) disable iff (!resetn)
		(rd_op && output_enable_n) |=> !data_io_bus_oe
			&& data_io_bus_out == $past(mem_r[word_address_in]);
	endproperty
	a_read_quiet: assert property (p_read_quiet)
		else $error("disabled read drove bus or skipped fetch");

	// writes never drive the bus whatever output enable shows
	property p_write_no_drive;
		@(posedge clk) disable iff (!resetn)
		wr_op |=> !data_io_bus_oe;
	endproperty
	a_write_no_drive: assert property (p_write_no_drive)
		else $error("bus driven during a write");

	// read of the last written address returns that word
	property p_raw;
		@(posedge clk) disable iff (!resetn)
		(rd_op && h_wv_r && word_address_in == h_wa_r) |=> data_io_bus_out == $past(h_wd_r);
	endproperty
	a_raw: assert property (p_raw)
		else $error("read after write returned stale data");

	// the drive enable only ever rises after a selected read edge
	property p_oe_cause;
		@(posedge clk) disable iff (!resetn)
		$rose(data_io_bus_oe) |-> $past(rd_op && !output_enable_n);
	endproperty
	a_oe_cause: assert property (p_oe_cause)
		else $error("bus drive rose without an enabled read");

	// a write leaves the read data register alone
	property p_write_keeps_out;
		@(posedge clk) disable iff (!resetn)
		wr_op |=> $stable(data_io_bus_out);
	endproperty
	a_write_keeps_out: assert property (p_write_keeps_out)
		else $error("write disturbed the read data");

	// reset releases the bus and clears the read data by the next edge;
	// no disable clause, since this one watches reset itself
	property p_reset_idle;
		@(posedge clk)
		!resetn |=> !data_io_bus_oe && data_io_bus_out == DATA_W'(sync_sram_pkg::DOUT_RST);
	endproperty
	a_reset_idle: assert property (p_reset_idle)
		else $error("reset left the bus driven or read data set");

	// main scenarios
	c_write_then_read: cover property (@(posedge clk) disable iff (!resetn)
		wr_op ##1 (rd_op && !output_enable_n && word_address_in == h_wa_r));
	c_quiet_read: cover property (@(posedge clk) disable iff (!resetn)
		rd_op && output_enable_n);
	c_desel_after_read: cover property (@(posedge clk) disable iff (!resetn)
		(rd_op && !output_enable_n) ##1 chip_select_n);
	c_back_to_back: cover property (@(posedge clk) disable iff (!resetn)
		rd_op ##1 wr_op ##1 rd_op);
	c_desel_write: cover property (@(posedge clk) disable iff (!resetn)
		chip_select_n && !write_enable_n);

endmodule // sync_sram_port

`default_nettype wire

/* hw/sync_sram_pkg.sv */
// shared constants for the synchronous static memory port
package sync_sram_pkg;

	// geometry of the array
	localparam int ADDR_W = 17;                     // word address width
	localparam int DATA_W = 16;                     // data word width
	localparam int DEPTH  = 1 << ADDR_W;            // number of words

	// values after reset
	localparam logic [DATA_W-1:0] DOUT_RST = 16'h0000; // read data register
	localparam logic              OE_RST   = 1'b0;     // pins released

	// the fastest legal host cycle and its length at this clock
	localparam int CLK_PERIOD_NS = 5;               // 200 MHz clock
	localparam int T_CYC_MIN_NS  = 25;              // 40 MHz operating limit
	localparam int CYC_MIN_CLKS  = (T_CYC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* verification/sram_host_model.sv */
// host controller model that drives the memory pins and the shared bus
`timescale 1ns/100ps
`default_nettype none
module sram_host_model (
	// clock and request from the bench
	input  wire logic        clk,
	input  wire logic        go,
	input  wire logic        wr,
	input  wire logic        rd_oe,
	input  wire logic [16:0] addr,
	input  wire logic [15:0] wdata,
	// memory side of the bus
	input  wire logic [15:0] dev_out,
	input  wire logic        dev_oe,
	// pins toward the memory
	output logic             chip_select_n,
	output logic             write_enable_n,
	output logic             output_enable_n,
	output logic      [16:0] word_address_in,
	output logic      [15:0] bus
);
	logic [15:0] last_r; // last bus level, inverted once nobody drives
	// one request per clock at most, held for the whole period
	assign chip_select_n   = !go;
	assign write_enable_n  = !wr;
	assign output_enable_n = !rd_oe;
	assign word_address_in = addr;
	// host drives only for writes; a released bus never shows a stale word
	always_comb begin
		if (dev_oe) begin
			bus = dev_out;
		end else if (go && wr) begin
			bus = wdata;
		end else begin
			bus = ~last_r;
		end
	end
	// remember the bus so a floating cycle differs from it
	always_ff @(posedge clk) begin
		last_r <= bus;
	end
endmodule // sram_host_model
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the synchronous memory port
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        clk, resetn, go, wr, rd_oe, oe, cs_n, we_n, oe_n; // clock, requests, pins
	logic [16:0] addr, a;    // requested and pin address
	logic [15:0] wdata, dout, bus; // write word, read word, bus level
	int          mismatches, checked; // counters
	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	sram_host_model i_host (.clk(clk), .go(go), .wr(wr), .rd_oe(rd_oe), .addr(addr),
		.wdata(wdata), .dev_out(dout), .dev_oe(oe), .chip_select_n(cs_n),
		.write_enable_n(we_n), .output_enable_n(oe_n), .word_address_in(a), .bus(bus));
	sync_sram_port i_dut (.clk(clk), .resetn(resetn), .chip_select_n(cs_n),
		.write_enable_n(we_n), .output_enable_n(oe_n), .word_address_in(a),
		.data_io_bus_in(bus), .data_io_bus_out(dout), .data_io_bus_oe(oe));
	// verdict and end of run
	task final_report;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// compare drive enable, read word and the bus level it produces
	task chk(input logic eo, input logic [15:0] ed);
		checked++;
		if (oe !== eo || dout !== ed || (eo && bus !== ed)) begin
			mismatches++;
			$display("CHECK FAILED t=%0t oe=%b out=%h exp %b %h", $time, oe, dout, eo, ed);
		end
	endtask
	// present one request just after a rising edge; o high enables read outputs
	task op(input logic g, w, o, input logic [16:0] ad, input logic [15:0] d);
		@(posedge clk);
		#1;
		go = g;
		wr = w;
		rd_oe = o;
		addr = ad;
		wdata = d;
	endtask
	// write both ends of the space, read back to back
	task t_rw;
		op(1'b1, 1'b1, 1'b0, 17'h00000, 16'h1234);
		op(1'b1, 1'b1, 1'b0, 17'h1ffff, 16'hedcb);
		op(1'b1, 1'b0, 1'b1, 17'h00000, 16'h0000);
		op(1'b1, 1'b0, 1'b1, 17'h1ffff, 16'h0000);
		chk(1'b1, 16'h1234);
		op(1'b0, 1'b0, 1'b0, 17'h00000, 16'h0000);
		chk(1'b1, 16'hedcb);
		$display("t_rw done");
	endtask
	// read with outputs disabled still fetches
	task t_hidden;
		op(1'b1, 1'b0, 1'b0, 17'h00000, 16'h0000);
		op(1'b0, 1'b0, 1'b0, 17'h00000, 16'h0000);
		chk(1'b0, 16'h1234);
		$display("t_hidden done");
	endtask
	// deselected write, then a select pulse only around the falling edge
	task t_desel;
		op(1'b0, 1'b1, 1'b0, 17'h00000, 16'hdead);
		@(negedge clk);
		go = 1'b1;
		#1;
		go = 1'b0;
		op(1'b0, 1'b0, 1'b0, 17'h00000, 16'h0000);
		chk(1'b0, 16'h1234);
		op(1'b1, 1'b0, 1'b1, 17'h00000, 16'h0000);
		op(1'b0, 1'b0, 1'b0, 17'h00000, 16'h0000);
		chk(1'b1, 16'h1234);
		$display("t_desel done");
	endtask
	// write with outputs enabled, then read it back
	task t_wr_oe;
		op(1'b1, 1'b1, 1'b1, 17'h0aaaa, 16'h5a5a);
		op(1'b1, 1'b0, 1'b1, 17'h0aaaa, 16'h0000);
		chk(1'b0, 16'h1234);
		op(1'b0, 1'b0, 1'b0, 17'h00000, 16'h0000);
		chk(1'b1, 16'h5a5a);
		$display("t_wr_oe done");
	endtask
	// watchdog far beyond the sixteen cycles the tests need
	initial begin
		#5000;
		mismatches++;
		final_report;
	end
	// reset for two edges, then the scenarios
	initial begin
		{go, wr, rd_oe, addr, wdata} = '0;
		resetn = 1'b0;
		mismatches = 0;
		checked = 0;
		repeat (2) @(posedge clk);
		#1;
		resetn = 1'b1;
		chk(1'b0, 16'h0000);
		t_rw;
		t_hidden;
		t_desel;
		t_wr_oe;
		final_report;
	end
endmodule // testbench
`default_nettype wire
